// [rtl/link_param_derivation.sv]
// Function
// - Lane bit rate is sample clock times R; R is the serializer PLL ratio.
// - One link mode code selects format and derives the other transport fields except K, device identifier and scrambling.
// - Frames per multiframe from user setting in 8B/10B only; ignored in 64B/66B.
// - Multiblocks per extended multiblock fixed at one in 64B/66B, unused otherwise.
// - 8B/10B sends all parameters in alignment sequence; 64B/66B sends none.
// - Adjust count, direction, bank, CF, HD, reserved are zero; versions are one.
// - Control bits per sample always zero in the alignment sequence.
// - Checksum is sum of the other thirteen alignment octets modulo 256.
// - Device identifier field carries the user value.
// - Each lane carries its own lane identifier.
// - Converter count follows lane packing, not physical channels.
// - Report raw resolution and transmitted sample width separately.
// - Report octets per frame and samples per converter per frame.
// - In 64B/66B effective K is 256 times E over F, not programmable.
// - Sync request starts code group sync then alignment sequence in 8B/10B.
`timescale 1ns/1ps
`include "link_param_defs.svh"

module link_param_derivation #(
    parameter int MF_LEN = 4
) (
    input  wire logic                       ref_clk,
    input  wire logic                       rst,
    input  wire logic [7:0]                 s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [7:0]                 s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    input  wire logic                       sync_req_n,
    output link_param_pkg::ilas_octet_t     ilas_out,
    output link_param_pkg::link_state_t     link_state,
    output logic [7:0]                      pll_ratio_x8
);
    import link_param_pkg::*;

    // Per-mode table; rate kept in eighths so fractional R stays exact
    function automatic mode_t decode_mode(input logic [4:0] code);
        mode_t m;
        m = '0;
        m.valid = 1'b1;
        unique case (code)
            5'h00: m = '{1'b1, ENC_8B10B, 5'd8, 5'd8, 8'd8, 5'd5, 5'd12, 5'd12, 5'd0,
                         8'd64, 8'd4};
            5'h01: m = '{1'b1, ENC_8B10B, 5'd6, 5'd4, 8'd2, 5'd2, 5'd12, 5'd12, 5'd1,
                         8'd80, 8'd16};
            5'h02: m = '{1'b1, ENC_8B10B, 5'd4, 5'd4, 8'd1, 5'd1, 5'd8, 5'd8, 5'd0,
                         8'd80, 8'd32};
            5'h03: m = '{1'b1, ENC_8B10B, 5'd4, 5'd4, 8'd5, 5'd4, 5'd10, 5'd10, 5'd0,
                         8'd100, 8'd32};
            5'h04: m = '{1'b1, ENC_64B66B, 5'd3, 5'd4, 8'd2, 5'd1, 5'd12, 5'd12, 5'd1,
                         8'd132, 8'd0};
            5'h05: m = '{1'b1, ENC_64B66B, 5'd2, 5'd4, 8'd2, 5'd1, 5'd8, 5'd8, 5'd0,
                         8'd132, 8'd0};
            5'h06: m = '{1'b1, ENC_64B66B, 5'd6, 5'd4, 8'd2, 5'd2, 5'd12, 5'd12, 5'd1,
                         8'd66, 8'd0};
            5'h07: m = '{1'b1, ENC_64B66B, 5'd4, 5'd4, 8'd1, 5'd1, 5'd8, 5'd8, 5'd0,
                         8'd66, 8'd0};
            5'h08: m = '{1'b1, ENC_64B66B, 5'd4, 5'd4, 8'd3, 5'd2, 5'd12, 5'd12, 5'd0,
                         8'd99, 8'd0};
            5'h09: m = '{1'b1, ENC_8B10B, 5'd8, 5'd4, 8'd1, 5'd2, 5'd8, 5'd8, 5'd0,
                         8'd40, 8'd32};
            5'h0A: m = '{1'b1, ENC_8B10B, 5'd8, 5'd8, 8'd5, 5'd4, 5'd10, 5'd10, 5'd0,
                         8'd50, 8'd32};
            5'h0E: m = '{1'b1, ENC_64B66B, 5'd8, 5'd8, 8'd3, 5'd2, 5'd12, 5'd12, 5'd0,
                         8'd49, 8'd0};
            default: m = '0;
        endcase
        return m;
    endfunction

    // Sum of octets modulo 256 by 8-bit wrap
    function automatic logic [7:0] add8(input logic [7:0] a, input logic [7:0] b);
        return 8'(a + b);
    endfunction

    // Register state
    logic [4:0]  mode_q, mode_d;
    user_cfg_t   cfg_q, cfg_d;
    logic        aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
    logic [7:0]  awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0]  wstrb_q, wstrb_d;
    logic        bvalid_q, bvalid_d;
    logic [1:0]  bresp_q, bresp_d;
    logic        rvalid_q, rvalid_d;
    logic [1:0]  rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic        mode_err_q, mode_err_d;

    // Link state
    link_state_t state_q, state_d;
    logic [2:0]  sync_sr_q, sync_sr_d;
    logic        sync_lvl_q, sync_lvl_d;
    logic [7:0]  cnt_q, cnt_d;
    logic [3:0]  oct_q, oct_d;
    logic [2:0]  lane_q, lane_d;
    ilas_octet_t ilas_q, ilas_d;
    logic [7:0]  pll_q, pll_d;

    mode_t       md;
    logic [7:0]  k_eff;
    logic [7:0]  field [0:13];
    logic [7:0]  chk;

    always_comb begin
        md = decode_mode(mode_q);
        // In 64B/66B K is derived, user setting dropped
        if (md.enc == ENC_64B66B) begin
            k_eff = 8'((16'd256 * 16'(`E_FIXED_VAL)) / 16'(md.octets) - 16'd1);
        end else begin
            k_eff = cfg_q.k_minus1;
        end
    end

    // Alignment octets for the current lane; minus-one encodings per link convention
    always_comb begin
        field[0]  = cfg_q.did;
        field[1]  = 8'h00;
        field[2]  = {3'h0, lane_q == 3'h0 ? 5'h00 : 5'(lane_q)};
        field[3]  = {cfg_q.scr, 2'h0, 5'(md.lanes - 5'd1)};
        field[4]  = 8'(md.octets - 8'd1);
        field[5]  = k_eff;
        field[6]  = {3'h0, 5'(md.conv - 5'd1)};
        field[7]  = {2'h0, 6'(md.res - 5'd1)};
        field[8]  = {`SUBCLASSV_VAL, 5'(md.width - 5'd1)};
        field[9]  = {`JESDV_VAL, 5'(md.samples - 5'd1)};
        field[10] = 8'h00;
        field[11] = 8'h00;
        field[12] = 8'h00;
        chk = 8'h00;
        for (int i = 0; i < 13; i++) begin
            chk = add8(chk, field[i]);
        end
        field[13] = chk;
    end

    // AXI4-Lite slave: address and data taken in either order
    always_comb begin
        logic [7:0]  wa;
        logic [7:0]  ra;
        wa = aw_hold_q ? awaddr_q : s_axi_awaddr;
        ra = s_axi_araddr;
        aw_hold_d = aw_hold_q;
        w_hold_d  = w_hold_q;
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        mode_d    = mode_q;
        cfg_d     = cfg_q;
        mode_err_d = mode_err_q;
        if (s_axi_awvalid && !aw_hold_q && !bvalid_q) begin
            aw_hold_d = 1'b1;
            awaddr_d  = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_hold_q && !bvalid_q) begin
            w_hold_d = 1'b1;
            wdata_d  = s_axi_wdata;
            wstrb_d  = s_axi_wstrb;
        end
        if (aw_hold_q && w_hold_q) begin
            aw_hold_d = 1'b0;
            w_hold_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = 2'b00;
            unique case (awaddr_q & 8'hFC)
                `REG_MODE_OFS: begin
                    if (wstrb_q[0]) begin
                        mode_d = wdata_q[4:0];
                        mode_err_d = !decode_mode(wdata_q[4:0]).valid;
                    end
                end
                `REG_CFG_OFS: begin
                    if (wstrb_q[0]) cfg_d.k_minus1 = wdata_q[7:0];
                    if (wstrb_q[1]) cfg_d.did = wdata_q[15:8];
                    if (wstrb_q[2]) cfg_d.scr = wdata_q[16];
                end
                `REG_STATUS_OFS, `REG_PARAM0_OFS, `REG_PARAM1_OFS, `REG_PARAM2_OFS,
                `REG_LANE_OFS: bresp_d = 2'b00;
                default: bresp_d = 2'b10;
            endcase
        end
        if (bvalid_q && s_axi_bready) bvalid_d = 1'b0;
        if (s_axi_arvalid && !rvalid_q) begin
            rvalid_d = 1'b1;
            rresp_d  = 2'b00;
            unique case (ra & 8'hFC)
                `REG_MODE_OFS:   rdata_d = {27'h0, mode_q};
                `REG_CFG_OFS:    rdata_d = {15'h0, cfg_q.scr, cfg_q.did, cfg_q.k_minus1};
                `REG_STATUS_OFS: rdata_d = {24'h0, md.rate_x8 == 8'h00, mode_err_q,
                                            3'h0, md.enc, 2'(state_q)};
                `REG_PARAM0_OFS: rdata_d = {3'h0, md.res, 3'h0, md.width, md.octets,
                                            3'h0, md.samples};
                `REG_PARAM1_OFS: rdata_d = {3'h0, md.lanes, 3'h0, md.conv, k_eff,
                                            md.rate_x8};
                `REG_PARAM2_OFS: rdata_d = {3'h0, md.hdens, md.kmin, `E_FIXED_VAL,
                                            chk};
                `REG_LANE_OFS:   rdata_d = {24'h0, 5'h00, lane_q};
                default: begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = 2'b10;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    // Link sequencer: sync request drives code group sync then alignment
    always_comb begin
        sync_sr_d  = {sync_sr_q[1:0], sync_req_n};
        sync_lvl_d = (sync_sr_q[1] == sync_sr_q[2]) ? sync_sr_q[2] : sync_lvl_q;
        state_d = state_q;
        cnt_d   = cnt_q;
        oct_d   = oct_q;
        lane_d  = lane_q;
        ilas_d  = '0;
        pll_d   = md.rate_x8;
        if (mode_d != mode_q) begin
            state_d = LNK_IDLE;
        end else begin
            unique case (state_q)
                LNK_IDLE: begin
                    if (md.valid && md.enc == ENC_64B66B) state_d = LNK_DATA;
                    else if (md.valid && !sync_lvl_q) state_d = LNK_CGS;
                end
                LNK_CGS: begin
                    if (sync_lvl_q) begin
                        state_d = LNK_ILAS;
                        cnt_d = 8'h00;
                        oct_d = 4'h0;
                        lane_d = 3'h0;
                    end
                end
                LNK_ILAS: begin
                    ilas_d.valid = 1'b1;
                    ilas_d.data  = field[oct_q];
                    ilas_d.index = oct_q;
                    ilas_d.lane  = lane_q;
                    ilas_d.last  = (oct_q == `ILAS_OCTETS - 4'h1) &&
                                   (5'(lane_q) == md.lanes - 5'd1) &&
                                   (cnt_q == 8'(MF_LEN - 1));
                    if (!sync_lvl_q) begin
                        state_d = LNK_CGS;
                    end else if (oct_q != `ILAS_OCTETS - 4'h1) begin
                        oct_d = oct_q + 4'h1;
                    end else if (5'(lane_q) != md.lanes - 5'd1) begin
                        oct_d = 4'h0;
                        lane_d = lane_q + 3'h1;
                    end else if (cnt_q != 8'(MF_LEN - 1)) begin
                        oct_d = 4'h0;
                        lane_d = 3'h0;
                        cnt_d = cnt_q + 8'h01;
                    end else begin
                        state_d = LNK_DATA;
                    end
                end
                LNK_DATA: begin
                    // Lost sync in 8B/10B restarts the whole alignment
                    if (md.enc == ENC_8B10B && !sync_lvl_q) state_d = LNK_CGS;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode_q     <= `MODE_RST;
            cfg_q      <= '{`DID_RST, `KM1_RST, `SCR_RST};
            aw_hold_q  <= 1'b0;
            w_hold_q   <= 1'b0;
            awaddr_q   <= 8'h00;
            wdata_q    <= 32'h0000_0000;
            wstrb_q    <= 4'h0;
            bvalid_q   <= 1'b0;
            bresp_q    <= 2'b00;
            rvalid_q   <= 1'b0;
            rresp_q    <= 2'b00;
            rdata_q    <= 32'h0000_0000;
            mode_err_q <= 1'b0;
            state_q    <= LNK_IDLE;
            sync_sr_q  <= 3'h7;
            sync_lvl_q <= 1'b1;
            cnt_q      <= 8'h00;
            oct_q      <= 4'h0;
            lane_q     <= 3'h0;
            ilas_q     <= '0;
            pll_q      <= 8'h00;
        end else begin
            mode_q     <= mode_d;
            cfg_q      <= cfg_d;
            aw_hold_q  <= aw_hold_d;
            w_hold_q   <= w_hold_d;
            awaddr_q   <= awaddr_d;
            wdata_q    <= wdata_d;
            wstrb_q    <= wstrb_d;
            bvalid_q   <= bvalid_d;
            bresp_q    <= bresp_d;
            rvalid_q   <= rvalid_d;
            rresp_q    <= rresp_d;
            rdata_q    <= rdata_d;
            mode_err_q <= mode_err_d;
            state_q    <= state_d;
            sync_sr_q  <= sync_sr_d;
            sync_lvl_q <= sync_lvl_d;
            cnt_q      <= cnt_d;
            oct_q      <= oct_d;
            lane_q     <= lane_d;
            ilas_q     <= ilas_d;
            pll_q      <= pll_d;
        end
    end

    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready  = !w_hold_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;
    assign ilas_out      = ilas_q;
    assign link_state    = state_q;
    assign pll_ratio_x8  = pll_q;

endmodule

// [rtl/link_param_defs.svh]
`ifndef LINK_PARAM_DEFS_SVH
`define LINK_PARAM_DEFS_SVH

// Register byte offsets
`define REG_MODE_OFS      8'h00
`define REG_CFG_OFS       8'h04
`define REG_STATUS_OFS    8'h08
`define REG_PARAM0_OFS    8'h0C
`define REG_PARAM1_OFS    8'h10
`define REG_PARAM2_OFS    8'h14
`define REG_LANE_OFS      8'h18

// Reset values
`define MODE_RST          5'h00
`define KM1_RST           8'h1F
`define DID_RST           8'h00
`define SCR_RST           1'h0

// Fixed alignment fields and limits
`define JESDV_VAL         3'h1
`define SUBCLASSV_VAL     3'h1
`define E_FIXED_VAL       8'h01
`define ILAS_OCTETS       4'hE
`define LANE_MAX          8
`define HIGHEST_MODE      5'h0F

`endif

// [rtl/link_param_pkg.sv]
package link_param_pkg;

    typedef enum logic {
        ENC_8B10B,
        ENC_64B66B
    } enc_t;

    typedef struct packed {
        logic       valid;
        enc_t       enc;
        logic [4:0] lanes;
        logic [4:0] conv;
        logic [7:0] octets;
        logic [4:0] samples;
        logic [4:0] res;
        logic [4:0] width;
        logic [4:0] hdens;
        logic [7:0] rate_x8;
        logic [7:0] kmin;
    } mode_t;

    typedef struct packed {
        logic [7:0] did;
        logic [7:0] k_minus1;
        logic       scr;
    } user_cfg_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic [3:0] index;
        logic [2:0] lane;
        logic       last;
    } ilas_octet_t;

    typedef enum logic [1:0] {
        LNK_IDLE,
        LNK_CGS,
        LNK_ILAS,
        LNK_DATA
    } link_state_t;

endpackage

// [test/link_rx_model.sv]
`timescale 1ns/1ps
module link_rx_model (
    input  wire logic                       ref_clk,
    input  wire logic                       rst,
    input  wire logic                       want_sync,
    input  wire logic [12:0][7:0]           exp_oct,
    input  wire link_param_pkg::ilas_octet_t ilas_out,
    output logic                            sync_req_n,
    output logic [15:0]                     oct_cnt,
    output logic [15:0]                     bad_cnt
);
    import link_param_pkg::*;
    logic [7:0] sum_q;
    logic [7:0] want;
    always_comb begin
        if (ilas_out.index == 4'hD)
            want = sum_q;
        else if (ilas_out.index == 4'h2)
            want = {5'h00, ilas_out.lane};
        else
            want = exp_oct[ilas_out.index];
    end
    // Checksum built from what we expect, not from what arrives
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync_req_n <= 1'b1;
            oct_cnt    <= 16'h0000;
            bad_cnt    <= 16'h0000;
            sum_q      <= 8'h00;
        end else begin
            sync_req_n <= !want_sync;
            if (ilas_out.valid) begin
                oct_cnt <= oct_cnt + 16'h0001;
                if (ilas_out.data !== want)
                    bad_cnt <= bad_cnt + 16'h0001;
                sum_q <= (ilas_out.index == 4'h0 ? 8'h00 : sum_q) + want;
            end
        end
    end
endmodule

// [test/link_param_derivation_props.sv]
`timescale 1ns/1ps
module link_param_derivation_props (
    input wire logic                        ref_clk,
    input wire logic                        rst,
    input wire logic                        s_axi_awvalid,
    input wire logic                        s_axi_awready,
    input wire logic                        s_axi_wvalid,
    input wire logic                        s_axi_wready,
    input wire logic                        s_axi_bvalid,
    input wire logic                        s_axi_arvalid,
    input wire logic                        s_axi_arready,
    input wire logic                        s_axi_rvalid,
    input wire logic                        sync_req_n,
    input wire link_param_pkg::ilas_octet_t ilas_out,
    input wire link_param_pkg::link_state_t link_state,
    input wire logic [7:0]                  pll_ratio_x8
);
    import link_param_pkg::*;
    logic [7:0] sum_q;
    logic [7:0] sum_d;
    always_comb begin
        sum_d = sum_q;
        if (ilas_out.valid)
            sum_d = (ilas_out.index == 4'h0 ? 8'h00 : sum_q) + ilas_out.data;
    end
    always_ff @(posedge ref_clk) begin
        if (rst)
            sum_q <= 8'h00;
        else
            sum_q <= sum_d;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Sync must be steady long enough to rule out a legal abort
    sequence seq_sync_steady;
        sync_req_n [*8];
    endsequence
    sequence seq_cgs_to_ilas;
        link_state == LNK_CGS ##1 link_state == LNK_ILAS;
    endsequence
    a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer missing");
    a_write_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write answer missing");
    a_ratio_legal:
    assert property (link_state != LNK_IDLE |-> pll_ratio_x8 != 8'h00)
        else $error("link up with zero ratio");
    a_ilas_source:
    assert property (ilas_out.valid |-> $past(link_state) == LNK_ILAS)
        else $error("octet outside alignment state");
    a_ilas_start:
    assert property (seq_cgs_to_ilas |-> ##[1:2]
        (ilas_out.valid && ilas_out.index == 4'h0 && ilas_out.lane == 3'h0))
        else $error("alignment did not start at octet zero");
    a_octet_order:
    assert property (seq_sync_steady ##0 (ilas_out.valid && ilas_out.index != 4'hD)
        |=> ilas_out.valid && ilas_out.index == $past(ilas_out.index) + 4'h1)
        else $error("octet order broken");
    a_zero_fields:
    assert property (ilas_out.valid && ilas_out.index inside {4'h1, 4'hA, 4'hB, 4'hC}
        |-> ilas_out.data == 8'h00) else $error("fixed field not zero");
    a_version_ones:
    assert property (ilas_out.valid && (ilas_out.index == 4'h8 || ilas_out.index == 4'h9)
        |-> ilas_out.data[7:5] == 3'h1) else $error("version field not one");
    a_cs_zero:
    assert property (ilas_out.valid && ilas_out.index == 4'h7 |-> ilas_out.data[7:6] == 2'h0)
        else $error("control bits field not zero");
    a_lane_ident:
    assert property (ilas_out.valid && ilas_out.index == 4'h2
        |-> ilas_out.data == {5'h00, ilas_out.lane}) else $error("lane id wrong");
    a_chksum_match:
    assert property (ilas_out.valid && ilas_out.index == 4'hD |-> ilas_out.data == sum_q)
        else $error("checksum wrong");
endmodule
bind link_param_derivation link_param_derivation_props link_param_derivation_props_i (
    .ref_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .sync_req_n,
    .ilas_out, .link_state, .pll_ratio_x8
);

// [test/test_link_param_derivation.sv]
`timescale 1ns/1ps
`include "link_param_defs.svh"
module test_link_param_derivation;
    import link_param_pkg::*;
    localparam int MFL = 1;
    logic             ref_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic             s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic             s_axi_rready, sync_req_n, want_sync;
    logic [7:0]       s_axi_awaddr, s_axi_araddr, pll_ratio_x8;
    logic [31:0]      s_axi_wdata, s_axi_rdata, rdat;
    logic [3:0]       s_axi_wstrb;
    logic [1:0]       s_axi_bresp, s_axi_rresp, rrsp;
    logic [15:0]      oct_cnt, bad_cnt;
    logic [12:0][7:0] exp_oct;
    ilas_octet_t      ilas_out;
    link_state_t      link_state;
    int               num_errors, comparisons;
    logic [7:0]       modes [10] = '{0, 1, 2, 3, 4, 5, 6, 7, 9, 10};
    logic [31:0]      p0 [10] = '{32'h0C0C0805, 32'h0C0C0202, 32'h08080101, 32'h0A0A0504,
        32'h0C0C0201, 32'h08080201, 32'h0C0C0202, 32'h08080101, 32'h08080102, 32'h0A0A0504};
    logic [31:0]      p1 [10] = '{32'h08081F40, 32'h06041F50, 32'h04041F50, 32'h04041F64,
        32'h03047F84, 32'h02047F84, 32'h06047F42, 32'h0404FF42, 32'h08041F28, 32'h08081F32};

    link_param_derivation #(.MF_LEN(MFL)) link_param_derivation_i (
        .ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sync_req_n, .ilas_out, .link_state,
        .pll_ratio_x8
    );
    link_rx_model link_rx_model_i (
        .ref_clk, .rst, .want_sync, .exp_oct, .ilas_out, .sync_req_n, .oct_cnt, .bad_cnt
    );

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (n < 64) begin
            @(posedge ref_clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            // Ready stays up so back-to-back calls never lower and raise it in one step
            if (s_axi_bvalid) begin
                chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
                n = 99;
            end
        end
        if (n < 99) chk("write answer", 32'h1, 32'h0);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m, input logic [1:0] er);
        int n;
        n = 0;
        rdat = 'x;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (n < 64) begin
            @(posedge ref_clk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                rdat = s_axi_rdata;
                rrsp = s_axi_rresp;
                n = 99;
            end
        end
        chk(nm, e & m, rdat & m);
        chk("rresp", {30'h0, er}, {30'h0, rrsp});
    endtask
    task automatic wait_data();
        for (int n = 0; n < 400 && link_state !== LNK_DATA; n++) @(posedge ref_clk);
        chk("link state", {30'h0, LNK_DATA}, {30'h0, link_state});
        // Last octet is counted by the receiver one edge after the state change
        @(posedge ref_clk);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // The whole sequence needs about three hundred cycles
    initial begin
        #(40 * 20000);
        num_errors++;
        results();
    end
    initial begin
        {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h10;
        {s_axi_rready, want_sync, s_axi_awaddr, s_axi_araddr} = 18'h0;
        {s_axi_wdata, s_axi_wstrb, exp_oct} = '0;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd("mode reset", `REG_MODE_OFS, 32'h0, 32'h1F, 2'h0);
        rd("cfg reset", `REG_CFG_OFS, 32'h1F, 32'h1FFFF, 2'h0);
        rd("unmapped", 8'h40, 32'h0, 32'hFFFFFFFF, 2'h2);
        wr(8'h44, 32'h1, 2'h2);
        wr(`REG_CFG_OFS, 32'h00015A1F, 2'h0);
        rd("cfg", `REG_CFG_OFS, 32'h00015A1F, 32'h1FFFF, 2'h0);
        for (int i = 0; i < 10; i++) begin
            wr(`REG_MODE_OFS, {24'h0, modes[i]}, 2'h0);
            rd("param0", `REG_PARAM0_OFS, p0[i], 32'h1F1FFF1F, 2'h0);
            rd("param1", `REG_PARAM1_OFS, p1[i], 32'h1F1FFFFF, 2'h0);
            rd("ext blocks", `REG_PARAM2_OFS, 32'h100, 32'hFF00, 2'h0);
            rd("encoding", `REG_STATUS_OFS, (modes[i] > 3 && modes[i] < 8) ? 4 : 0, 4, 0);
            chk("pll ratio", {24'h0, p1[i][7:0]}, {24'h0, pll_ratio_x8});
        end
        wr(`REG_CFG_OFS, 32'h00015A3F, 2'h0);
        rd("k setting", `REG_PARAM1_OFS, 32'h08083F32, 32'h1F1FFFFF, 2'h0);
        wr(`REG_PARAM0_OFS, 32'hFFFFFFFF, 2'h0);
        rd("param0 kept", `REG_PARAM0_OFS, 32'h0A0A0504, 32'h1F1FFF1F, 2'h0);
        wr(`REG_MODE_OFS, 32'hB, 2'h0);
        rd("illegal mode", `REG_STATUS_OFS, 32'h80, 32'h80, 2'h0);
        chk("ratio illegal", 32'h0, {24'h0, pll_ratio_x8});
        wr(`REG_MODE_OFS, 32'h0, 2'h0);
        exp_oct <= {8'h00, 8'h00, 8'h00, 8'h24, 8'h2B, 8'h0B, 8'h07, 8'h3F, 8'h07,
                    8'h87, 8'h00, 8'h00, 8'h5A};
        want_sync <= 1'b1;
        repeat (10) @(posedge ref_clk);
        chk("sync state", {30'h0, LNK_CGS}, {30'h0, link_state});
        want_sync <= 1'b0;
        wait_data();
        chk("ilas octets", 14 * 8 * MFL, {16'h0, oct_cnt});
        chk("ilas fields", 32'h0, {16'h0, bad_cnt});
        wr(`REG_MODE_OFS, 32'h4, 2'h0);
        repeat (8) @(posedge ref_clk);
        wait_data();
        chk("no ilas", 14 * 8 * MFL, {16'h0, oct_cnt});
        results();
    end
endmodule
